// ==== pkg/rtc_ctrl_pkg.sv ====
// Package: register map, field positions and timing constants of the clock unit control block
package rtc_ctrl_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] off_control = 8'h00;
  localparam logic [7:0] off_time = 8'h04;
  localparam logic [7:0] off_system = 8'h08;
  localparam logic [31:0] control_reset = 32'h0000_0000;

  // ****************************************
  // Control field positions
  // ****************************************
  localparam int trim_lsb = 16;
  localparam int trim_msb = 25;
  localparam int enable_bit = 15;
  localparam int stop_in_idle_bit = 13;
  localparam int output_source_select_bit = 7;
  localparam int timebase_running_status_bit = 6;
  localparam int write_guard_enable_bit = 3;
  localparam int rollover_sync_flag_bit = 2;
  localparam int half_second_flag_bit = 1;
  localparam int output_pin_enable_bit = 0;
  localparam logic [31:0] control_writable = 32'h03ff_a089;

  // ****************************************
  // Time register seconds field and system register
  // ****************************************
  localparam int seconds_lsb = 8;
  localparam int seconds_msb = 14;
  localparam int unlock_bit = 0;
  localparam int idle_bit = 1;

  // ****************************************
  // Time base
  // ****************************************
  localparam int timebase_hz = 32768;
  localparam int pulses_per_half_second = timebase_hz / 2;
  localparam int half_seconds_per_minute = 120;
  localparam int clock_mhz = 100;
  localparam int clock_period_ns = 10;
  localparam int sync_window_half_seconds = 1;
endpackage

// ==== rtl/edge_sync.sv ====
// Three-stage synchroniser for an outside level, with agreement check
`timescale 1ns/100ps
module edge_sync (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Level in and out
  input wire logic raw,
  output logic level,
  output logic rise
);
  logic stage1;
  logic stage2;
  logic stage3;

  // Only stage2 reads stage1; level changes once stage2 and stage3 agree
  always_ff @(posedge clock) begin
    if (rst) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      level <= 1'b0;
      rise <= 1'b0;
    end else begin
      stage1 <= raw;
      stage2 <= stage1;
      stage3 <= stage2;
      rise <= (stage2 == stage3) && stage3 && !level;
      if (stage2 == stage3) begin
        level <= stage3;
      end
    end
  end
endmodule

// ==== rtl/trim_counter.sv ====
// Half-second divider of time-base pulses with once-a-minute signed trim
`timescale 1ns/100ps
module trim_counter #(
  parameter int pulses_per_half = 16384,
  parameter int halves_per_minute = 120
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Control
  input wire logic run,
  input wire logic tick,
  input wire logic [9:0] trim,
  // Events
  output logic half_tick,
  output logic minute_tick,
  output logic half_level
);
  // Refuse lengths that the 17-bit count, the 7-bit half count or the trim range cannot serve
  if (pulses_per_half < 1024 || pulses_per_half > 65535) begin : g_bad_length
    $error("pulses_per_half out of range");
  end
  if (halves_per_minute < 2 || halves_per_minute > 128) begin : g_bad_halves
    $error("halves_per_minute out of range");
  end

  logic [16:0] count;
  logic [6:0] halves;
  logic [16:0] limit;
  logic [16:0] base_limit;
  logic [16:0] trim_ext;
  logic last_half;
  logic wrap;

  // Trim applies to the last half second of each minute only
  assign base_limit = 17'(pulses_per_half - 1);
  assign trim_ext = {{7{trim[9]}}, trim};
  assign last_half = (halves == 7'(halves_per_minute - 1));
  // Positive trim stretches, negative trim shortens the final half second
  assign limit = last_half ? base_limit + trim_ext : base_limit;
  assign wrap = tick && (count >= limit);

  // Pulse counting; disabled unit holds everything at zero
  always_ff @(posedge clock) begin
    if (rst || !run) begin
      count <= '0;
      halves <= '0;
      half_tick <= 1'b0;
      minute_tick <= 1'b0;
      half_level <= 1'b0;
    end else begin
      half_tick <= wrap;
      minute_tick <= wrap && last_half;
      if (wrap) begin
        count <= '0;
        half_level <= !half_level;
        halves <= last_half ? 7'h00 : halves + 7'h01;
      end else if (tick) begin
        count <= count + 17'h00001;
      end
    end
  end
endmodule

// ==== rtl/rtc_control.sv ====
// Control and status register of the clock and calendar unit, on APB
`timescale 1ns/100ps
module rtc_control
  import rtc_ctrl_pkg::*;
#(
  parameter int pulses_per_half = pulses_per_half_second,
  parameter int running_timeout = 8
) (
  // Clock and resets
  input wire logic clock,
  input wire logic rst,
  input wire logic other_reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // System inputs
  input wire logic unlock_active,
  input wire logic cpu_idle,
  input wire logic timebase_clk_in,
  input wire logic alarm_pulse,
  // Unit outputs
  output logic unit_pin,
  output logic unit_enable,
  output logic bus_clock_gate
);
  import rtc_ctrl_pkg::*;

  // Timeout must fit the 8-bit idle counter
  if (running_timeout < 2 || running_timeout > 255) begin : g_bad_timeout
    $error("running_timeout out of range");
  end

  // ****************************************
  // Register state
  // ****************************************
  logic [9:0] trim;
  logic enable;
  logic stop_in_idle;
  logic output_source_select;
  logic write_guard_enable;
  logic output_pin_enable;
  logic half_second_flag;
  logic rollover_sync_flag;
  logic timebase_running_status;
  logic [7:0] idle_count;
  logic tb_rise;
  logic half_tick;
  logic half_level;
  logic [31:0] control_view;
  logic [31:0] next_prdata;
  logic access;
  logic wr_control;
  logic wr_time;
  logic wr_seconds;
  logic known_addr;
  logic next_pin;

  // ****************************************
  // Time base input and divider
  // ****************************************
  edge_sync u_sync (
    .clock(clock),
    .rst(rst),
    .raw(timebase_clk_in),
    .level(),
    .rise(tb_rise)
  );

  trim_counter #(
    .pulses_per_half(pulses_per_half),
    .halves_per_minute(half_seconds_per_minute)
  ) u_trim (
    .clock(clock),
    .rst(rst),
    .run(enable),
    .tick(tb_rise),
    .trim(trim),
    .half_tick(half_tick),
    .minute_tick(),
    .half_level(half_level)
  );

  // ****************************************
  // APB decode
  // ****************************************
  assign access = psel && penable;
  assign known_addr = (paddr == off_control) || (paddr == off_time);
  assign wr_control = access && pwrite && (paddr == off_control);
  assign wr_time = access && pwrite && (paddr == off_time);
  // Any write to the time word touches its seconds fields
  assign wr_seconds = wr_time;
  // Read view; unimplemented bits stay zero
  assign control_view = {6'h00, trim, enable, 1'b0, stop_in_idle, 5'h00,
    output_source_select, timebase_running_status, 2'b00, write_guard_enable,
    rollover_sync_flag, half_second_flag, output_pin_enable};
  // Read data is loaded at the setup edge so that it stands in the access cycle
  assign next_prdata = (psel && !penable && !pwrite && paddr == off_control) ?
    control_view : 32'h0;

  // Bus answer registers; zero-wait answer in the access cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pready <= psel && !penable && !pready;
      pslverr <= psel && !penable && !known_addr;
    end
  end

  // ****************************************
  // Control register, cleared only by power-on reset
  // ****************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      trim <= control_reset[trim_msb:trim_lsb];
      enable <= 1'b0;
      stop_in_idle <= 1'b0;
      output_source_select <= 1'b0;
      write_guard_enable <= 1'b0;
      output_pin_enable <= 1'b0;
    end else if (wr_control && pready) begin
      trim <= pwdata[trim_msb:trim_lsb];
      stop_in_idle <= pwdata[stop_in_idle_bit];
      output_source_select <= pwdata[output_source_select_bit];
      output_pin_enable <= pwdata[output_pin_enable_bit];
      if (write_guard_enable) begin
        enable <= pwdata[enable_bit];
      end
      write_guard_enable <= pwdata[write_guard_enable_bit] && unlock_active;
    end
  end

  // ****************************************
  // Status flags
  // ****************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      half_second_flag <= 1'b0;
      rollover_sync_flag <= 1'b0;
      timebase_running_status <= 1'b0;
      idle_count <= 8'h00;
    end else begin
      // Hardware toggle wins over the software clear
      if (half_tick) begin
        half_second_flag <= half_level;
      end else if (wr_seconds && pready) begin
        half_second_flag <= 1'b0;
      end
      rollover_sync_flag <= enable && half_level && !half_second_flag;
      // Running while edges keep arriving within the timeout
      if (tb_rise) begin
        idle_count <= 8'h00;
        timebase_running_status <= 1'b1;
      end else if (idle_count == 8'(running_timeout)) begin
        timebase_running_status <= 1'b0;
      end else begin
        idle_count <= idle_count + 8'h01;
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign next_pin = output_pin_enable && enable &&
    (output_source_select ? half_level : alarm_pulse);

  always_ff @(posedge clock) begin
    if (rst) begin
      unit_pin <= 1'b0;
      unit_enable <= 1'b0;
      bus_clock_gate <= 1'b0;
    end else begin
      unit_pin <= next_pin;
      unit_enable <= enable;
      bus_clock_gate <= stop_in_idle && cpu_idle;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_guard_blocks_enable: assert property (@(posedge clock) disable iff (rst)
    (wr_control && pready && !write_guard_enable) |=> $stable(enable))
    else $error("enable changed without write guard");
  a_guard_needs_unlock: assert property (@(posedge clock) disable iff (rst)
    $rose(write_guard_enable) |-> $past(unlock_active))
    else $error("write guard set without unlock");
  a_pin_needs_oe: assert property (@(posedge clock) disable iff (rst)
    !output_pin_enable |=> !unit_pin)
    else $error("pin active without output enable");
  a_pin_source_sel: assert property (@(posedge clock) disable iff (rst)
    (output_pin_enable && enable && !output_source_select) |=> unit_pin == $past(alarm_pulse))
    else $error("pin does not follow alarm pulse");
  a_idle_gate: assert property (@(posedge clock) disable iff (rst)
    (stop_in_idle && cpu_idle) |=> bus_clock_gate)
    else $error("bus clock not gated in idle");
  a_unit_enable: assert property (@(posedge clock) disable iff (rst)
    unit_enable == $past(enable))
    else $error("unit enable does not follow bit");
  a_half_clear: assert property (@(posedge clock) disable iff (rst)
    (wr_seconds && pready && !half_tick) |=> !half_second_flag)
    else $error("half second flag not cleared");
  a_reserved_zero: assert property (@(posedge clock) disable iff (rst)
    (prdata & ~control_writable & 32'hffff_ffb9) == 32'h0)
    else $error("reserved bits read nonzero");
  a_other_reset: assert property (@(posedge clock) disable iff (rst)
    (other_reset && !(wr_control && pready)) |=> $stable(trim))
    else $error("control changed on other reset");
endmodule

// ==== bench/test_rtc_control.sv ====
// Testbench: register access, guard, pin, idle and status checks of the control block
`timescale 1ns/100ps
module test_rtc_control;
  import rtc_ctrl_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic clock;
  logic rst;
  logic other_reset;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic unlock_active;
  logic cpu_idle;
  logic timebase_clk_in;
  logic alarm_pulse;
  logic unit_pin;
  logic unit_enable;
  logic bus_clock_gate;
  logic tb_run;
  logic tb_phase;
  logic [31:0] q;
  logic e;
  int mismatches;
  int cmp_count;
  int cycles;
  int n;

  // Status bits 6, 2 and 1 are left out of word compares
  localparam logic [31:0] ro_mask = 32'h0000_0046;

  // ****************************************
  // Design under test
  // ****************************************
  rtc_control #(.pulses_per_half(1024), .running_timeout(8)) rtc_control_inst (
    .clock(clock), .rst(rst), .other_reset(other_reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .unlock_active(unlock_active), .cpu_idle(cpu_idle),
    .timebase_clk_in(timebase_clk_in), .alarm_pulse(alarm_pulse),
    .unit_pin(unit_pin), .unit_enable(unit_enable), .bus_clock_gate(bus_clock_gate)
  );

  // Clock generator
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Time-base source, one rising edge every four clocks while running
  // Each level holds two clocks so the agreement filter can see it
  always @(posedge clock) begin
    if (tb_run) begin
      tb_phase <= ~tb_phase;
      if (tb_phase) begin
        timebase_clk_in <= ~timebase_clk_in;
      end
    end
  end

  // Hang guard
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      mismatches = mismatches + 1;
      final_report();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  // Compare one value
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer: setup, access until pready, release, one idle cycle
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) begin
      @(posedge clock);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock); // Idle cycle after each transfer, also after clearing enable
  endtask

  // Read control and compare all but the status bits
  task automatic rd_ctrl(input logic [31:0] exp);
    apb(1'b0, off_control, 32'h0000_0000);
    chk("control", q & ~ro_mask, exp);
  endtask

  // Print counts and verdict, then stop
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst = 1'b1;
    other_reset = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    unlock_active = 1'b0;
    cpu_idle = 1'b0;
    timebase_clk_in = 1'b0;
    alarm_pulse = 1'b0;
    tb_run = 1'b0;
    tb_phase = 1'b0;
    mismatches = 0;
    cmp_count = 0;
    cycles = 0;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk("outputs after reset", {unit_enable, unit_pin, bus_clock_gate}, 32'h0);
    apb(1'b0, off_control, 32'h0000_0000);
    chk("control reset", q, control_reset);
    // Write all ones while locked: reserved, guard and enable stay clear
    apb(1'b1, off_control, 32'hffff_ffff);
    rd_ctrl(control_writable & ~32'h0000_8008);
    chk("enable locked", unit_enable, 32'h0);
    // Other resets leave the register alone
    @(posedge clock) other_reset <= 1'b1;
    repeat (3) @(posedge clock);
    other_reset <= 1'b0;
    @(posedge clock);
    rd_ctrl(control_writable & ~32'h0000_8008);
    // Unlock, set guard; enable in the same write is still refused
    unlock_active <= 1'b1;
    apb(1'b1, off_control, 32'h0000_8009);
    rd_ctrl(32'h0000_0009);
    apb(1'b1, off_control, 32'h0000_8009);
    rd_ctrl(32'h0000_8009);
    chk("enable set", unit_enable, 32'h1);
    // Alarm pulse drives the pin when enabled, nothing when not
    alarm_pulse <= 1'b1;
    repeat (4) @(posedge clock);
    chk("pin alarm", unit_pin, 32'h1);
    apb(1'b1, off_control, 32'h0000_8008);
    repeat (3) @(posedge clock);
    chk("pin disabled", unit_pin, 32'h0);
    alarm_pulse <= 1'b0;
    // Stop in idle gates the bus clock only during idle
    apb(1'b1, off_control, 32'h0000_a008);
    cpu_idle <= 1'b1;
    repeat (4) @(posedge clock);
    chk("gate idle", bus_clock_gate, 32'h1);
    cpu_idle <= 1'b0;
    repeat (4) @(posedge clock);
    chk("gate busy", bus_clock_gate, 32'h0);
    // Time base running status, half-second flag and its clear
    tb_run <= 1'b1;
    repeat (40) @(posedge clock);
    apb(1'b0, off_control, 32'h0000_0000);
    chk("running", q[timebase_running_status_bit], 32'h1);
    n = 0;
    while (q[half_second_flag_bit] !== 1'b1 && n < 4000) begin
      n++;
      apb(1'b0, off_control, 32'h0000_0000);
    end
    chk("half second seen", q[half_second_flag_bit], 32'h1);
    tb_run <= 1'b0;
    repeat (40) @(posedge clock);
    apb(1'b0, off_control, 32'h0000_0000);
    chk("stopped", q[timebase_running_status_bit], 32'h0);
    apb(1'b1, off_time, 32'h0000_3b00);
    apb(1'b0, off_control, 32'h0000_0000);
    chk("half second cleared", q[half_second_flag_bit], 32'h0);
    // Seconds clock is frozen high with the time base stopped; alarm is low
    apb(1'b1, off_control, 32'h0000_8089);
    repeat (2) @(posedge clock);
    chk("pin seconds", unit_pin, 32'h1);
    apb(1'b1, off_control, 32'h0000_a008);
    // Unmapped address is refused and writes nothing
    apb(1'b1, 8'h0c, 32'hffff_ffff);
    chk("unmapped error", e, 32'h1);
    rd_ctrl(32'h0000_a008);
    // Clear enable and guard together, then try to re-enable while locked
    apb(1'b1, off_control, 32'h0000_2000);
    rd_ctrl(32'h0000_2000);
    chk("enable cleared", unit_enable, 32'h0);
    unlock_active <= 1'b0;
    apb(1'b1, off_control, 32'h0000_a008);
    rd_ctrl(32'h0000_2000);
    chk("enable refused", unit_enable, 32'h0);
    final_report();
  end
endmodule
